//--- inc/bobe_pkg.sv
package bobe_pkg;

  // ----------------------------------------------------------------
  // Opcodes with a fixed code
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CARRY_AND_BIT = 8'h8b;
  localparam logic [7:0] OP_CARRY_XOR_BIT = 8'hab;
  localparam logic [7:0] OP_CARRY_OR_BIT = 8'h6b;
  localparam logic [7:0] OP_LOAD_CARRY_FROM_BIT = 8'hcb;
  localparam logic [7:0] OP_BIT_TEST_DP = 8'h0c;
  localparam logic [7:0] OP_BIT_TEST_ABS = 8'h1c;
  localparam logic [7:0] OP_RAISE_ACC_BIT = 8'h0b;
  localparam logic [7:0] OP_CLEAR_ACC_BIT = 8'h2b;
  localparam logic [7:0] OP_FORCE_CARRY_LOW = 8'h20;
  localparam logic [7:0] OP_FORCE_CARRY_HIGH = 8'ha0;
  localparam logic [7:0] OP_PAGE_FLAG_LOW = 8'h40;
  localparam logic [7:0] OP_PAGE_FLAG_HIGH = 8'hc0;
  localparam logic [7:0] OP_FORCE_OVERFLOW_LOW = 8'h80;
  localparam logic [7:0] OP_COMPLEMENT_MEM_BIT = 8'h4b;
  localparam logic [7:0] OP_STORE_CARRY_TO_BIT = 8'heb;
  localparam logic [7:0] OP_TEST_AND_CLEAR_BITS = 8'h5c;
  localparam logic [7:0] OP_TEST_AND_RAISE_BITS = 8'h3c;
  localparam logic [7:0] OP_BRANCH_CARRY_LOW = 8'h50;
  localparam logic [7:0] OP_BRANCH_CARRY_HIGH = 8'hd0;
  localparam logic [7:0] OP_BRANCH_IF_ZERO_FLAG = 8'hf0;
  localparam logic [7:0] OP_BRANCH_IF_NONZERO = 8'h70;
  localparam logic [7:0] OP_BRANCH_IF_NEGATIVE = 8'h90;
  localparam logic [7:0] OP_BRANCH_IF_POSITIVE = 8'h10;
  localparam logic [7:0] OP_BRANCH_UNCONDITIONAL = 8'h2f;
  localparam logic [7:0] OP_BRANCH_OVERFLOW_LOW = 8'h30;
  localparam logic [7:0] OP_BRANCH_OVERFLOW_HIGH = 8'hb0;

  // ----------------------------------------------------------------
  // Patterned opcodes: bit number in [7:5], clear form has [4] set
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_MEM_BIT = 4'h1;
  localparam logic [3:0] NIB_BRANCH_ACC_BIT = 4'h2;
  localparam logic [3:0] NIB_BRANCH_DP_BIT = 4'h3;
  localparam int OPC_BIT_HI = 7;
  localparam int OPC_BIT_LO = 5;
  localparam int OPC_CLEAR_FORM = 4;

  // ----------------------------------------------------------------
  // Memory-bit operand word {byte2, byte1}
  // ----------------------------------------------------------------
  localparam int MB_BIT_HI = 15;
  localparam int MB_BIT_LO = 13;
  localparam int MB_INVERT = 12;
  localparam int MB_ADDR_HI = 11;
  localparam logic [15:0] DP_PAGE1_BASE = 16'h0100;

  // ----------------------------------------------------------------
  // Status word positions and reset values
  // ----------------------------------------------------------------
  localparam int PSW_N = 7;
  localparam int PSW_V = 6;
  localparam int PSW_G = 5;
  localparam int PSW_H = 3;
  localparam int PSW_Z = 1;
  localparam int PSW_C = 0;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Lengths and cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_CARRY_AND = 3'h4;
  localparam logic [2:0] CYC_CARRY_XOR = 3'h5;
  localparam logic [2:0] CYC_CARRY_OR = 3'h5;
  localparam logic [2:0] CYC_LOAD_CARRY = 3'h4;
  localparam logic [2:0] CYC_BIT_TEST_DP = 3'h4;
  localparam logic [2:0] CYC_BIT_TEST_ABS = 3'h5;
  localparam logic [2:0] CYC_MEM_BIT = 3'h4;
  localparam logic [2:0] CYC_ACC_BIT = 3'h2;
  localparam logic [2:0] CYC_FLAG = 3'h2;
  localparam logic [2:0] CYC_COMPLEMENT = 3'h5;
  localparam logic [2:0] CYC_STORE_CARRY = 3'h6;
  localparam logic [2:0] CYC_TEST_MODIFY = 3'h6;
  localparam logic [2:0] CYC_BRB_ACC_NT = 3'h4;
  localparam logic [2:0] CYC_BRB_ACC_T = 3'h6;
  localparam logic [2:0] CYC_BRB_DP_NT = 3'h5;
  localparam logic [2:0] CYC_BRB_DP_T = 3'h7;
  localparam logic [2:0] CYC_BR_NT = 3'h2;
  localparam logic [2:0] CYC_BR_T = 3'h4;
  localparam logic [2:0] CYC_BR_ALWAYS = 3'h4;
  localparam logic [2:0] CYC_UNKNOWN = 3'h2;

  typedef enum logic [3:0] {
    CL_NONE = 4'b0000,
    CL_CARRY_LOGIC = 4'b0001,
    CL_BIT_TEST = 4'b0010,
    CL_MEM_BIT_WRITE = 4'b0011,
    CL_ACC_BIT = 4'b0100,
    CL_FLAG = 4'b0101,
    CL_COMPLEMENT = 4'b0110,
    CL_STORE_CARRY = 4'b0111,
    CL_TEST_MODIFY = 4'b1000,
    CL_BRANCH_ACC_BIT = 4'b1001,
    CL_BRANCH_DP_BIT = 4'b1010,
    CL_BRANCH_FLAG = 4'b1011
  } bobe_class_e;

endpackage

//--- design/bobe_decode.sv
`timescale 1ns/1ps
module bobe_decode (
  // Opcode in
  input wire logic [7:0] opcode,
  // Decoded shape
  output bobe_pkg::bobe_class_e op_class,
  output logic [1:0] op_len,
  output logic [2:0] cyc_not_taken,
  output logic [2:0] cyc_taken,
  output logic op_legal
);
  import bobe_pkg::*;

  always_comb begin
    op_class = CL_NONE;
    op_len = LEN_1;
    cyc_not_taken = CYC_UNKNOWN;
    cyc_taken = CYC_UNKNOWN;
    op_legal = 1'b1;
    unique case (opcode)
      OP_CARRY_AND_BIT: begin
        op_class = CL_CARRY_LOGIC; op_len = LEN_3; cyc_not_taken = CYC_CARRY_AND;
      end
      OP_CARRY_XOR_BIT: begin
        op_class = CL_CARRY_LOGIC; op_len = LEN_3; cyc_not_taken = CYC_CARRY_XOR;
      end
      OP_CARRY_OR_BIT: begin
        op_class = CL_CARRY_LOGIC; op_len = LEN_3; cyc_not_taken = CYC_CARRY_OR;
      end
      OP_LOAD_CARRY_FROM_BIT: begin
        op_class = CL_CARRY_LOGIC; op_len = LEN_3; cyc_not_taken = CYC_LOAD_CARRY;
      end
      OP_BIT_TEST_DP: begin
        op_class = CL_BIT_TEST; op_len = LEN_2; cyc_not_taken = CYC_BIT_TEST_DP;
      end
      OP_BIT_TEST_ABS: begin
        op_class = CL_BIT_TEST; op_len = LEN_3; cyc_not_taken = CYC_BIT_TEST_ABS;
      end
      OP_RAISE_ACC_BIT, OP_CLEAR_ACC_BIT: begin
        op_class = CL_ACC_BIT; op_len = LEN_2; cyc_not_taken = CYC_ACC_BIT;
      end
      OP_FORCE_CARRY_LOW, OP_FORCE_CARRY_HIGH, OP_PAGE_FLAG_LOW, OP_PAGE_FLAG_HIGH,
      OP_FORCE_OVERFLOW_LOW: begin
        op_class = CL_FLAG; cyc_not_taken = CYC_FLAG;
      end
      OP_COMPLEMENT_MEM_BIT: begin
        op_class = CL_COMPLEMENT; op_len = LEN_3; cyc_not_taken = CYC_COMPLEMENT;
      end
      OP_STORE_CARRY_TO_BIT: begin
        op_class = CL_STORE_CARRY; op_len = LEN_3; cyc_not_taken = CYC_STORE_CARRY;
      end
      OP_TEST_AND_CLEAR_BITS, OP_TEST_AND_RAISE_BITS: begin
        op_class = CL_TEST_MODIFY; op_len = LEN_3; cyc_not_taken = CYC_TEST_MODIFY;
      end
      OP_BRANCH_CARRY_LOW, OP_BRANCH_CARRY_HIGH, OP_BRANCH_IF_ZERO_FLAG, OP_BRANCH_IF_NONZERO,
      OP_BRANCH_IF_NEGATIVE, OP_BRANCH_IF_POSITIVE, OP_BRANCH_OVERFLOW_LOW,
      OP_BRANCH_OVERFLOW_HIGH: begin
        op_class = CL_BRANCH_FLAG; op_len = LEN_2; cyc_not_taken = CYC_BR_NT;
      end
      OP_BRANCH_UNCONDITIONAL: begin
        op_class = CL_BRANCH_FLAG; op_len = LEN_2; cyc_not_taken = CYC_BR_ALWAYS;
      end
      default: begin
        if (opcode[3:0] == NIB_MEM_BIT) begin
          op_class = CL_MEM_BIT_WRITE; op_len = LEN_2; cyc_not_taken = CYC_MEM_BIT;
        end else if (opcode[3:0] == NIB_BRANCH_ACC_BIT) begin
          op_class = CL_BRANCH_ACC_BIT; op_len = LEN_2; cyc_not_taken = CYC_BRB_ACC_NT;
        end else if (opcode[3:0] == NIB_BRANCH_DP_BIT) begin
          op_class = CL_BRANCH_DP_BIT; op_len = LEN_3; cyc_not_taken = CYC_BRB_DP_NT;
        end else begin
          op_legal = 1'b0;
        end
      end
    endcase
    // A taken branch stretches the instruction; everything else is fixed.
    unique case (op_class)
      CL_BRANCH_ACC_BIT: cyc_taken = CYC_BRB_ACC_T;
      CL_BRANCH_DP_BIT: cyc_taken = CYC_BRB_DP_T;
      CL_BRANCH_FLAG: cyc_taken = (opcode == OP_BRANCH_UNCONDITIONAL) ? CYC_BR_ALWAYS : CYC_BR_T;
      default: cyc_taken = cyc_not_taken;
    endcase
  end

endmodule

//--- design/bobe_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 8B, 3 bytes, 4 cycles: carry AND memory bit or its inverse.
// - AB, 3 bytes, 5 cycles: carry XOR memory bit or its inverse.
// - 6B, 3 bytes, 5 cycles: carry OR memory bit or its inverse.
// - CB, 3 bytes, 4 cycles: carry loaded from memory bit or its inverse.
// - Bit test 0C/1C: zero from A AND M, negative M7, overflow M6.
// - x1/y1 on direct-page bit: 2 bytes, 4 cycles, write 1 or 0.
// - 0B/2B, 2 bytes, 2 cycles: set or clear one accumulator bit.
// - 20 and A0, one byte, 2 cycles: carry to 0 or 1.
// - 40 and C0, one byte, 2 cycles: page flag to 0 or 1.
// - 80, one byte, 2 cycles: overflow and half-carry cleared.
// - 4B, 3 bytes, 5 cycles: memory bit inverted and written back.
// - EB, 3 bytes, 6 cycles: memory bit written with carry.
// - 5C, 6 cycles: N,Z from A minus M; M becomes M AND NOT A.
// - 3C, 6 cycles: N,Z from A minus M; M becomes M OR A.
// - Branch on bit y2/y3 clear, x2/x3 set; 4/6 and 5/7 cycles.
// - 50/D0 branch on carry 0/1, 2 bytes, 2/4 cycles.
// - F0 branches on zero set, 70 on zero clear, 2/4 cycles.
// - 90 branches on negative set, 10 on clear, 2/4 cycles.
// - 2F always branches, 2 bytes, 4 cycles.
// - 30 branches on overflow clear, 2 bytes, 2/4 cycles.
// - B0 branches on overflow set, 2 bytes, 2/4 cycles.
module bobe_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Program memory, data valid in the cycle the address stands
  output logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  // Data memory, read data valid in the cycle the address stands
  output logic [15:0] data_addr,
  output logic data_rd_en,
  output logic data_wr_en,
  output logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  // Register preload, taken in the opcode fetch cycle
  input wire logic preload_en,
  input wire logic [7:0] preload_acc,
  input wire logic [7:0] preload_psw,
  // Status
  output logic [7:0] acc_out,
  output logic [7:0] psw_out,
  output logic instr_done,
  output logic bad_opcode
);
  import bobe_pkg::*;

  typedef struct packed {
    logic [2:0] cyc;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] psw;
    logic taken;
    logic [15:0] daddr;
    logic re;
    logic we;
    logic [7:0] wdata;
    logic done;
    logic bad;
  } bobe_state_s;

  bobe_state_s s_q;
  bobe_state_s s_d;

  logic [7:0] op_cur;
  bobe_class_e op_class;
  logic [1:0] op_len;
  logic [2:0] cyc_nt;
  logic [2:0] cyc_t;
  logic op_legal;

  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx, input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction

  function automatic logic [15:0] dp_addr(input logic [7:0] off, input logic page);
    return page ? (DP_PAGE1_BASE | {8'h00, off}) : {8'h00, off};
  endfunction

  assign op_cur = (s_q.cyc == 3'h0) ? prog_data : s_q.op;

  bobe_decode u_decode (
    .opcode(op_cur),
    .op_class(op_class),
    .op_len(op_len),
    .cyc_not_taken(cyc_nt),
    .cyc_taken(cyc_t),
    .op_legal(op_legal)
  );

  // ----------------------------------------------------------------
  // Sequencing and execution
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [2:0] len3;
    logic [2:0] dec_cyc;
    logic [2:0] bitsel;
    logic inv;
    logic mbit;
    logic taken_now;
    logic tk;
    logic [2:0] total;
    logic [7:0] rel;
    logic [7:0] diff;
    taken_now = 1'b0;
    tk = 1'b0;
    total = 3'h0;
    dec_cyc = 3'h0;
    byte1 = (s_q.cyc == 3'h1) ? prog_data : s_q.b1;
    byte2 = (s_q.cyc == 3'h2) ? prog_data : s_q.b2;
    len3 = {1'b0, op_len};
    bitsel = (op_len == LEN_3 && op_class != CL_BRANCH_DP_BIT) ?
             s_q.b2[MB_BIT_HI-8:MB_BIT_LO-8] : op_cur[OPC_BIT_HI:OPC_BIT_LO];
    inv = (op_class == CL_CARRY_LOGIC) && s_q.b2[MB_INVERT-8];
    mbit = data_rdata[bitsel];
    diff = s_q.acc - data_rdata;
    rel = (op_class == CL_BRANCH_DP_BIT) ? s_q.b2 : s_q.b1;
    s_d = s_q;
    s_d.re = 1'b0;
    s_d.we = 1'b0;
    s_d.done = 1'b0;
    s_d.bad = 1'b0;
    if (s_q.cyc == 3'h0 && preload_en) begin
      s_d.acc = preload_acc;
      s_d.psw = preload_psw;
    end
    // Bytes are fetched one per cycle; the program counter then points past the instruction.
    if (s_q.cyc < len3) begin
      s_d.pc = s_q.pc + 16'h0001;
    end
    if (s_q.cyc == 3'h0) begin
      s_d.op = prog_data;
    end
    if (s_q.cyc == 3'h1) begin
      s_d.b1 = prog_data;
    end
    if (s_q.cyc == 3'h2) begin
      s_d.b2 = prog_data;
    end
    // The operand address is registered in the last fetch cycle so the read lands right after.
    if (s_q.cyc == len3 - 3'h1) begin
      unique case (op_class)
        CL_CARRY_LOGIC, CL_COMPLEMENT, CL_STORE_CARRY: begin
          s_d.daddr = {4'h0, byte2[MB_ADDR_HI-8:0], byte1};
          s_d.re = 1'b1;
        end
        CL_BIT_TEST, CL_TEST_MODIFY: begin
          s_d.daddr = (op_len == LEN_2) ? dp_addr(byte1, s_d.psw[PSW_G]) : {byte2, byte1};
          s_d.re = 1'b1;
        end
        CL_MEM_BIT_WRITE, CL_BRANCH_DP_BIT: begin
          s_d.daddr = dp_addr(byte1, s_d.psw[PSW_G]);
          s_d.re = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Single-byte flag forcing acts in the opcode cycle.
    if (s_q.cyc == 3'h0 && op_class == CL_FLAG) begin
      unique case (op_cur)
        OP_FORCE_CARRY_LOW: s_d.psw[PSW_C] = 1'b0;
        OP_FORCE_CARRY_HIGH: s_d.psw[PSW_C] = 1'b1;
        OP_PAGE_FLAG_LOW: s_d.psw[PSW_G] = 1'b0;
        OP_PAGE_FLAG_HIGH: s_d.psw[PSW_G] = 1'b1;
        default: begin
          s_d.psw[PSW_V] = 1'b0;
          s_d.psw[PSW_H] = 1'b0;
        end
      endcase
    end
    if (s_q.cyc == 3'h1 && op_class == CL_ACC_BIT) begin
      s_d.acc = put_bit(s_d.acc, prog_data[2:0], op_cur == OP_RAISE_ACC_BIT);
    end
    // Memory operand cycle.
    if (s_q.cyc == len3 && s_q.cyc != 3'h0) begin
      s_d.wdata = data_rdata;
      unique case (op_class)
        CL_CARRY_LOGIC: begin
          unique case (op_cur)
            OP_CARRY_AND_BIT: s_d.psw[PSW_C] = s_q.psw[PSW_C] & (mbit ^ inv);
            OP_CARRY_XOR_BIT: s_d.psw[PSW_C] = s_q.psw[PSW_C] ^ (mbit ^ inv);
            OP_CARRY_OR_BIT: s_d.psw[PSW_C] = s_q.psw[PSW_C] | (mbit ^ inv);
            default: s_d.psw[PSW_C] = mbit ^ inv;
          endcase
        end
        CL_BIT_TEST: begin
          s_d.psw[PSW_Z] = (s_q.acc & data_rdata) == 8'h00;
          s_d.psw[PSW_N] = data_rdata[7];
          s_d.psw[PSW_V] = data_rdata[6];
        end
        CL_MEM_BIT_WRITE: begin
          s_d.wdata = put_bit(data_rdata, bitsel, !op_cur[OPC_CLEAR_FORM]);
          s_d.we = 1'b1;
        end
        CL_COMPLEMENT: begin
          s_d.wdata = put_bit(data_rdata, bitsel, !mbit);
          s_d.we = 1'b1;
        end
        CL_STORE_CARRY: begin
          s_d.wdata = put_bit(data_rdata, bitsel, s_q.psw[PSW_C]);
          s_d.we = 1'b1;
        end
        CL_TEST_MODIFY: begin
          s_d.psw[PSW_N] = diff[7];
          s_d.psw[PSW_Z] = diff == 8'h00;
          s_d.wdata = (op_cur == OP_TEST_AND_CLEAR_BITS) ? (data_rdata & ~s_q.acc)
                                                         : (data_rdata | s_q.acc);
          s_d.we = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Branch decision: flag forms decide on the offset byte, bit-on-memory on the operand.
    dec_cyc = (op_class == CL_BRANCH_DP_BIT) ? len3 : len3 - 3'h1;
    unique case (op_class)
      CL_BRANCH_FLAG: begin
        unique case (op_cur)
          OP_BRANCH_CARRY_LOW: taken_now = !s_q.psw[PSW_C];
          OP_BRANCH_CARRY_HIGH: taken_now = s_q.psw[PSW_C];
          OP_BRANCH_IF_ZERO_FLAG: taken_now = s_q.psw[PSW_Z];
          OP_BRANCH_IF_NONZERO: taken_now = !s_q.psw[PSW_Z];
          OP_BRANCH_IF_NEGATIVE: taken_now = s_q.psw[PSW_N];
          OP_BRANCH_IF_POSITIVE: taken_now = !s_q.psw[PSW_N];
          OP_BRANCH_OVERFLOW_LOW: taken_now = !s_q.psw[PSW_V];
          OP_BRANCH_OVERFLOW_HIGH: taken_now = s_q.psw[PSW_V];
          default: taken_now = 1'b1;
        endcase
      end
      CL_BRANCH_ACC_BIT: taken_now = s_q.acc[op_cur[OPC_BIT_HI:OPC_BIT_LO]] ^ op_cur[OPC_CLEAR_FORM];
      CL_BRANCH_DP_BIT: taken_now = data_rdata[op_cur[OPC_BIT_HI:OPC_BIT_LO]] ^ op_cur[OPC_CLEAR_FORM];
      default: taken_now = 1'b0;
    endcase
    if (s_q.cyc == dec_cyc) begin
      s_d.taken = taken_now;
    end
    tk = (s_q.cyc == dec_cyc) ? taken_now : s_q.taken;
    total = tk ? cyc_t : cyc_nt;
    if (s_q.cyc == total - 3'h1) begin
      if (tk) begin
        s_d.pc = s_q.pc + {{8{rel[7]}}, rel};
      end
      s_d.cyc = 3'h0;
      s_d.taken = 1'b0;
      s_d.done = 1'b1;
      s_d.bad = !op_legal;
    end else begin
      s_d.cyc = s_q.cyc + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.pc <= PC_RST;
      s_q.acc <= ACC_RST;
      s_q.psw <= PSW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prog_addr = s_q.pc;
  assign data_addr = s_q.daddr;
  assign data_rd_en = s_q.re;
  assign data_wr_en = s_q.we;
  assign data_wdata = s_q.wdata;
  assign acc_out = s_q.acc;
  assign psw_out = s_q.psw;
  assign instr_done = s_q.done;
  assign bad_opcode = s_q.bad;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic first;
  assign first = s_q.cyc == 3'h0;

  chk_carry_low_two: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_FORCE_CARRY_LOW) |-> ##2 (instr_done && !psw_out[PSW_C]))
    else $error("carry clear did not finish in two cycles with carry low");

  chk_page_high_two: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_PAGE_FLAG_HIGH) |-> ##1 !instr_done ##1 (instr_done && psw_out[PSW_G]))
    else $error("page flag set wrong or mistimed");

  chk_always_branch_pc: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_BRANCH_UNCONDITIONAL) |-> ##4 (instr_done &&
      prog_addr == $past(prog_addr, 3) + 16'h0001 + {{8{$past(prog_data[7], 3)}}, $past(prog_data, 3)}))
    else $error("unconditional branch target or timing wrong");

  chk_carry_branch_skip: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_BRANCH_CARRY_LOW && (preload_en ? preload_psw[PSW_C] : psw_out[PSW_C])) |-> ##2
      (instr_done && prog_addr == $past(prog_addr, 2) + 16'h0002))
    else $error("untaken carry branch not two cycles");

  chk_branch_keeps_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_BRANCH_UNCONDITIONAL) |-> ##4 (psw_out == $past(psw_out, 3)))
    else $error("branch altered the status word");

  chk_acc_bit_raise: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_RAISE_ACC_BIT) |-> ##2
      (instr_done && acc_out == ($past(acc_out, 1) | (8'h01 << $past(prog_data[2:0], 1)))))
    else $error("accumulator bit set wrong");

  chk_store_carry_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_STORE_CARRY_TO_BIT) |-> ##3 data_rd_en ##1 data_wr_en ##2 instr_done)
    else $error("carry store sequence mistimed");

  chk_test_raise_data: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_TEST_AND_RAISE_BITS) |-> ##4 (data_wr_en && data_wdata == ($past(data_rdata, 1) | acc_out))
    ##2 instr_done)
    else $error("test and set wrote wrong value or mistimed");

  chk_bit_test_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    (first && prog_data == OP_BIT_TEST_ABS) |-> ##5 (instr_done && psw_out[PSW_N] == $past(data_rdata[7], 2) &&
      psw_out[PSW_V] == $past(data_rdata[6], 2)))
    else $error("bit test flags or timing wrong");

  chk_done_single: assert property (@(posedge core_clk) disable iff (!reset_n)
    instr_done |=> !instr_done)
    else $error("instruction shorter than two cycles");

endmodule

//--- testbench/bobe_mem.sv
`timescale 1ns/1ps
module bobe_mem (
  // Clock
  input wire logic core_clk,
  // Program side
  input wire logic [15:0] prog_addr,
  output logic [7:0] prog_data,
  // Data side
  input wire logic [15:0] data_addr,
  input wire logic data_rd_en,
  input wire logic data_wr_en,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata
);
  logic [7:0] pmem [0:255];
  logic [7:0] dmem [0:511];
  assign prog_data = pmem[prog_addr[7:0]];
  // Outside a read strobe the lines show the inverted byte, so a late sample cannot match by luck.
  assign data_rdata = data_rd_en ? dmem[data_addr[8:0]] : ~dmem[data_addr[8:0]];
  always @(posedge core_clk) begin
    if (data_wr_en) begin
      dmem[data_addr[8:0]] <= data_wdata;
    end
  end
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import bobe_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] prog_addr, data_addr;
  logic [7:0] prog_data, data_wdata, data_rdata, acc_out, psw_out;
  logic data_rd_en, data_wr_en, instr_done, bad_opcode;
  logic preload_en = 1'b0;
  logic [7:0] preload_acc = 8'h00;
  logic [7:0] preload_psw = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic [7:0] ops [8] = '{8'h50, 8'hd0, 8'hf0, 8'h70, 8'h90, 8'h10, 8'h30, 8'hb0};
  logic [7:0] fl [8] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h80, 8'h00, 8'h00, 8'h40};
  int error_cnt = 0;
  int comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  bobe_core i_dut (.core_clk(core_clk), .reset_n(reset_n), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .preload_en(preload_en), .preload_acc(preload_acc), .preload_psw(preload_psw),
    .acc_out(acc_out), .psw_out(psw_out), .instr_done(instr_done), .bad_opcode(bad_opcode));
  bobe_mem i_mem (.core_clk(core_clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .data_wdata(data_wdata), .data_rdata(data_rdata));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Entered in cycle 0 of an instruction; the preload rides on that fetch cycle.
  task automatic ex(input logic [23:0] ins, input int cyc, input logic [7:0] pa, pp, ea, ep,
      input logic [15:0] npc, input logic bad = 1'b0);
    int n;
    i_mem.pmem[pc[7:0]] = ins[7:0];
    i_mem.pmem[pc[7:0] + 8'h01] = ins[15:8];
    i_mem.pmem[pc[7:0] + 8'h02] = ins[23:16];
    preload_en = 1'b1;
    preload_acc = pa;
    preload_psw = pp;
    @(negedge core_clk);
    preload_en = 1'b0;
    n = 1;
    while (instr_done !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    if (instr_done !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    chk("cycles", 16'(n), 16'(cyc));
    chk("acc", {8'h00, acc_out}, {8'h00, ea});
    chk("psw", {8'h00, psw_out}, {8'h00, ep});
    chk("next_pc", prog_addr, npc);
    chk("bad_opcode", {15'h0000, bad_opcode}, {15'h0000, bad});
    pc = npc;
  endtask
  initial begin
    i_mem.dmem[8'h12] = 8'h20;
    i_mem.dmem[8'h13] = 8'h00;
    i_mem.dmem[8'h30] = 8'hc0;
    i_mem.dmem[8'h40] = 8'h00;
    i_mem.dmem[8'h50] = 8'hf0;
    i_mem.dmem[8'h51] = 8'h0c;
    i_mem.dmem[8'h60] = 8'h01;
    i_mem.dmem[9'h140] = 8'h00;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    ex(24'h20, 2, 8'h00, 8'hff, 8'h00, 8'hfe, pc + 16'h1);
    ex(24'ha0, 2, 8'h00, 8'h00, 8'h00, 8'h01, pc + 16'h1);
    ex(24'h40, 2, 8'h00, 8'hff, 8'h00, 8'hdf, pc + 16'h1);
    ex(24'hc0, 2, 8'h00, 8'h00, 8'h00, 8'h20, pc + 16'h1);
    ex(24'h80, 2, 8'h00, 8'hff, 8'h00, 8'hb7, pc + 16'h1);
    ex(24'h030b, 2, 8'h00, 8'h00, 8'h08, 8'h00, pc + 16'h2);
    ex(24'h072b, 2, 8'hff, 8'h00, 8'h7f, 8'h00, pc + 16'h2);
    ex(24'ha0128b, 4, 8'h00, 8'h01, 8'h00, 8'h01, pc + 16'h3);
    ex(24'hb0128b, 4, 8'h00, 8'hc3, 8'h00, 8'hc2, pc + 16'h3);
    ex(24'ha012ab, 5, 8'h00, 8'h01, 8'h00, 8'h00, pc + 16'h3);
    ex(24'hb012ab, 5, 8'h00, 8'hc3, 8'h00, 8'hc3, pc + 16'h3);
    ex(24'ha0126b, 5, 8'h00, 8'h00, 8'h00, 8'h01, pc + 16'h3);
    ex(24'hb0126b, 5, 8'h00, 8'hc2, 8'h00, 8'hc2, pc + 16'h3);
    ex(24'ha012cb, 4, 8'h00, 8'h00, 8'h00, 8'h01, pc + 16'h3);
    ex(24'hb012cb, 4, 8'h00, 8'h01, 8'h00, 8'h00, pc + 16'h3);
    ex(24'ha0124b, 5, 8'h00, 8'hc3, 8'h00, 8'hc3, pc + 16'h3);
    chk("mem_12", {8'h00, i_mem.dmem[8'h12]}, 16'h0000);
    ex(24'h0013eb, 6, 8'h00, 8'h01, 8'h00, 8'h01, pc + 16'h3);
    chk("mem_13", {8'h00, i_mem.dmem[8'h13]}, 16'h0001);
    ex(24'h300c, 4, 8'h0f, 8'h00, 8'h0f, 8'hc2, pc + 16'h2);
    ex(24'h00301c, 5, 8'h0f, 8'h00, 8'h0f, 8'hc2, pc + 16'h3);
    ex(24'h4041, 4, 8'h00, 8'h00, 8'h00, 8'h00, pc + 16'h2);
    chk("mem_40", {8'h00, i_mem.dmem[8'h40]}, 16'h0004);
    ex(24'h4051, 4, 8'h00, 8'h00, 8'h00, 8'h00, pc + 16'h2);
    chk("mem_40", {8'h00, i_mem.dmem[8'h40]}, 16'h0000);
    ex(24'h4041, 4, 8'h00, 8'h20, 8'h00, 8'h20, pc + 16'h2);
    chk("mem_140", {8'h00, i_mem.dmem[9'h140]}, 16'h0004);
    chk("mem_40_page0", {8'h00, i_mem.dmem[8'h40]}, 16'h0000);
    ex(24'h00505c, 6, 8'h30, 8'h82, 8'h30, 8'h00, pc + 16'h3);
    chk("mem_50", {8'h00, i_mem.dmem[8'h50]}, 16'h00c0);
    ex(24'h00513c, 6, 8'h30, 8'h82, 8'h30, 8'h00, pc + 16'h3);
    chk("mem_51", {8'h00, i_mem.dmem[8'h51]}, 16'h003c);
    ex(24'h7f22, 6, 8'h02, 8'h00, 8'h02, 8'h00, pc + 16'h81);
    ex(24'h8032, 4, 8'h02, 8'h00, 8'h02, 8'h00, pc + 16'h2);
    ex(24'h806003, 7, 8'h00, 8'h00, 8'h00, 8'h00, pc + 16'hff83);
    ex(24'h806013, 5, 8'h00, 8'h00, 8'h00, 8'h00, pc + 16'h3);
    for (int i = 0; i < 8; i++) begin
      ex({16'h0080, ops[i]}, 4, 8'h00, fl[i], 8'h00, fl[i], pc + 16'hff82);
      ex({16'h0080, ops[i]}, 2, 8'h00, ~fl[i], 8'h00, ~fl[i], pc + 16'h2);
    end
    ex(24'h052f, 4, 8'h00, 8'h00, 8'h00, 8'h00, pc + 16'h7);
    ex(24'hff, 2, 8'h5a, 8'h5a, 8'h5a, 8'h5a, pc + 16'h1, 1'b1);
    end_of_test();
  end
endmodule
